// ===== sdec_core.sv
/*
 * sdec_core: serial command interface and decoder of a twelve channel 8-bit
 * dac with a 12-bit parallel port expander. Shift logic runs on the host's
 * shift clock; decoding and all state run on sys_clk.
 * Assumes: shift clock idles low and stands still while chip select is high,
 * chip select stays high long enough for sys_clk to execute (see note),
 * the analog converter itself lies outside and reads the codes and enables.
 *
 */
`timescale 1ns/1ps
`default_nettype none

module sdec_core (
	// system clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// serial link from host
	input wire logic shift_clk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// parallel port pins
	input wire logic [sdec_pkg::PORT_W-1:0] parallel_port_pins_in,
	output logic [sdec_pkg::PORT_W-1:0] parallel_port_pins_out,
	output logic [sdec_pkg::PORT_W-1:0] parallel_port_pins_oe,
	// analog channel control toward the converter
	output logic [sdec_pkg::NUM_CH-1:0][sdec_pkg::CODE_W-1:0] analog_channel_codes,
	output logic [sdec_pkg::NUM_CH-1:0] analog_channel_outputs_en
);

	// decode of one command word into its kind
	function automatic sdec_pkg::sdec_cmd_e decode_cmd(
		input logic [sdec_pkg::CMD_W-1:0] w
	);
		logic [sdec_pkg::SEL_W-1:0] sel;
		logic [sdec_pkg::OP_W-1:0] op;
		sdec_pkg::sdec_cmd_e k;
		sel = w[sdec_pkg::SEL_LSB +: sdec_pkg::SEL_W];
		op = w[sdec_pkg::OP_LSB +: sdec_pkg::OP_W];
		k = sdec_pkg::CMD_NONE;
		unique case (sel)
			sdec_pkg::SEL_SPECIAL: begin
				if (op == sdec_pkg::OP_ALL_LOAD) begin
					k = sdec_pkg::CMD_ALL_LOAD;
				end else if (op == sdec_pkg::OP_ALL_HIZ) begin
					k = sdec_pkg::CMD_ALL_HIZ;
				end else if (op == sdec_pkg::OP_RESET) begin
					k = sdec_pkg::CMD_RESET;
				end
			end
			sdec_pkg::SEL_PORT_WR: k = sdec_pkg::CMD_PORT_WR;
			sdec_pkg::SEL_PORT_RD: k = sdec_pkg::CMD_PORT_RD;
			sdec_pkg::SEL_DIR_WR: k = sdec_pkg::CMD_DIR_WR;
			default: begin
				// remaining codes 1..12 are channel selectors
				if (op == sdec_pkg::OP_CH_LOAD) begin
					k = sdec_pkg::CMD_CH_LOAD;
				end else if (op == sdec_pkg::OP_CH_HIZ) begin
					k = sdec_pkg::CMD_CH_HIZ;
				end
			end
		endcase
		return k;
	endfunction

	// ---------------- link domain ----------------
	logic link_clr;
	logic in_frame;
	logic frame_tgl;
	logic so_live;
	logic so_reg;
	logic [sdec_pkg::CMD_W-1:0] link_sr;
	logic [sdec_pkg::CMD_W-1:0] link_base;
	// sys domain word the link starts each frame from; static during frames
	logic [sdec_pkg::CMD_W-1:0] shadow;

	// frame state is cleared by the frame's own end, not by a clock edge
	assign link_clr = chip_select_n | ~arst_n;

	// first edge of a frame shifts from the sys side copy
	assign link_base = in_frame ? link_sr : shadow;

	// marks that this frame has seen a rising shift clock
	always_ff @(posedge shift_clk or posedge link_clr) begin
		if (link_clr) begin
			in_frame <= 1'b0;
		end else begin
			in_frame <= 1'b1;
		end
	end

	// serial shift, new bit enters at the top, lsb leaves first
	always_ff @(posedge shift_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_sr <= sdec_pkg::SHIFT_RST;
		end else if (!chip_select_n) begin
			link_sr <= {serial_in, link_base[sdec_pkg::CMD_W-1:1]};
		end
	end

	// one toggle per clocked frame, tells sys which copy holds the word
	always_ff @(posedge shift_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_tgl <= 1'b0;
		end else if (!chip_select_n && !in_frame) begin
			frame_tgl <= ~frame_tgl;
		end
	end

	// output bit moves on the falling edge, half a period after the shift
	always_ff @(negedge shift_clk or negedge arst_n) begin
		if (!arst_n) begin
			so_reg <= 1'b0;
		end else begin
			so_reg <= link_sr[0];
		end
	end

	// until the first falling edge the start word's lsb is shown
	always_ff @(negedge shift_clk or posedge link_clr) begin
		if (link_clr) begin
			so_live <= 1'b0;
		end else begin
			so_live <= in_frame;
		end
	end

	// serial output and its enable
	assign serial_out = so_live ? so_reg : shadow[0];
	assign serial_out_oe = ~chip_select_n;

	// ---------------- sys domain ----------------
	logic [sdec_pkg::SYNC_W-1:0] sync_q;
	logic cs_s;
	logic cs_q;
	logic tgl_s;
	logic frame_seen;
	logic exec;
	logic [sdec_pkg::PORT_W-1:0] pins_s;
	logic [sdec_pkg::CMD_W-1:0] word;
	sdec_pkg::sdec_cmd_e cmd;
	logic [sdec_pkg::SEL_W-1:0] ch_idx;
	logic [sdec_pkg::CODE_W-1:0] payload_code;
	logic [sdec_pkg::PORT_W-1:0] payload_port;
	logic [sdec_pkg::PORT_W-1:0] pin_dir;
	logic [sdec_pkg::PORT_W-1:0] port_out;
	logic [sdec_pkg::NUM_CH-1:0] analog_on;
	logic [sdec_pkg::PORT_W-1:0] pin_analog;
	logic [sdec_pkg::PORT_W-1:0] read_val;

	// chip select, frame toggle and port pins all cross through two flops
	sdec_sync #(
		.WIDTH(sdec_pkg::SYNC_W),
		.RST_VAL(sdec_pkg::SYNC_RST)
	) u_sync (
		.clk(sys_clk),
		.arst_n(arst_n),
		.async_in({chip_select_n, frame_tgl, parallel_port_pins_in}),
		.sync_out(sync_q)
	);

	assign cs_s = sync_q[sdec_pkg::SYNC_CS_BIT];
	assign tgl_s = sync_q[sdec_pkg::SYNC_TGL_BIT];
	assign pins_s = sync_q[sdec_pkg::PORT_W-1:0];

	// rising chip select runs the command once
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_q <= 1'b1;
		end else begin
			cs_q <= cs_s;
		end
	end

	assign exec = cs_s & ~cs_q;

	// link_sr is quiet by now: the shift clock stopped two flops ago
	assign word = (tgl_s != frame_seen) ? link_sr : shadow;
	assign cmd = exec ? decode_cmd(word) : sdec_pkg::CMD_NONE;
	assign ch_idx = word[sdec_pkg::SEL_LSB +: sdec_pkg::SEL_W] - sdec_pkg::SEL_CH_FIRST;
	assign payload_code = word[sdec_pkg::CODE_LSB +: sdec_pkg::CODE_W];
	assign payload_port = word[sdec_pkg::PORT_LSB +: sdec_pkg::PORT_W];

	// remembers which frame toggle was already consumed
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_seen <= 1'b0;
		end else if (exec) begin
			frame_seen <= tgl_s;
		end
	end

	// pins that carry a channel in analog use
	genvar gp;
	generate
		for (gp = 0; gp < sdec_pkg::PORT_W; gp++) begin : g_pin
			if (gp < sdec_pkg::ANALOG_PIN_LO) begin : g_dig
				assign pin_analog[gp] = 1'b0;
			end else begin : g_shared
				assign pin_analog[gp] = analog_on[sdec_pkg::PIN_CH_BASE - gp];
			end
		end
	endgenerate

	// masked pin levels for a read
	assign read_val = pins_s & ~pin_dir & ~pin_analog;

	// channel codes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			analog_channel_codes <= {sdec_pkg::NUM_CH{sdec_pkg::CODE_RST}};
		end else begin
			unique case (cmd)
				sdec_pkg::CMD_ALL_LOAD: begin
					analog_channel_codes <= {sdec_pkg::NUM_CH{payload_code}};
				end
				sdec_pkg::CMD_RESET: begin
					analog_channel_codes <= {sdec_pkg::NUM_CH{sdec_pkg::CODE_RST}};
				end
				sdec_pkg::CMD_CH_LOAD: begin
					analog_channel_codes[ch_idx] <= payload_code;
				end
				default: begin
				end
			endcase
		end
	end

	// analog use per channel; channels 1..4 can never float
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			analog_on <= sdec_pkg::ANALOG_RST;
		end else begin
			unique case (cmd)
				sdec_pkg::CMD_ALL_LOAD: begin
					analog_on <= '1;
				end
				sdec_pkg::CMD_ALL_HIZ: begin
					analog_on <= sdec_pkg::ANALOG_RST;
				end
				sdec_pkg::CMD_RESET: begin
					analog_on <= sdec_pkg::ANALOG_RST;
				end
				sdec_pkg::CMD_CH_LOAD: begin
					analog_on[ch_idx] <= 1'b1;
				end
				sdec_pkg::CMD_CH_HIZ: begin
					if (ch_idx >= sdec_pkg::SEL_W'(sdec_pkg::FIRST_HIZ_CH)) begin
						analog_on[ch_idx] <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// pin direction register, write only from the host
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_dir <= sdec_pkg::DIR_RST;
		end else begin
			unique case (cmd)
				sdec_pkg::CMD_DIR_WR: pin_dir <= payload_port;
				sdec_pkg::CMD_RESET: pin_dir <= sdec_pkg::DIR_RST;
				default: begin
				end
			endcase
		end
	end

	// parallel output register survives the reset command
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_out <= sdec_pkg::PORT_RST;
		end else if (cmd == sdec_pkg::CMD_PORT_WR) begin
			port_out <= payload_port;
		end
	end

	// word the next frame starts from: last word, read data or cleared top
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow <= sdec_pkg::SHIFT_RST;
		end else if (exec) begin
			unique case (cmd)
				sdec_pkg::CMD_PORT_RD: begin
					// sampled at chip select rise
					shadow <= {read_val, word[sdec_pkg::PORT_LSB-1:0]};
				end
				sdec_pkg::CMD_RESET: begin
					// low byte kept
					shadow <= {sdec_pkg::SHIFT_HI_CLR, word[sdec_pkg::CODE_LSB-1:0]};
				end
				default: shadow <= word;
			endcase
		end
	end

	// port pins: output only where direction says so
	assign parallel_port_pins_out = port_out;
	assign parallel_port_pins_oe = pin_dir;

	// direction 1 takes a shared pin away from its channel while set
	genvar gc;
	generate
		for (gc = 0; gc < sdec_pkg::NUM_CH; gc++) begin : g_ch
			if (gc < sdec_pkg::FIRST_HIZ_CH) begin : g_fixed
				assign analog_channel_outputs_en[gc] = analog_on[gc];
			end else begin : g_shared
				assign analog_channel_outputs_en[gc] =
					analog_on[gc] & ~pin_dir[sdec_pkg::PIN_CH_BASE - gc];
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ===== sdec_pkg.sv
/*
 * sdec_pkg: shared constants for the serial dac / port expander command block.
 * Command word layout, selector and operation codes, reset values and the
 * command kind enumeration. Assumes nothing of its surroundings.
 */
`default_nettype none

package sdec_pkg;

	// command word layout
	localparam int CMD_W = 16;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;
	localparam int OP_LSB = 4;
	localparam int OP_W = 4;
	localparam int CODE_LSB = 8;
	localparam int CODE_W = 8;
	localparam int PORT_LSB = 4;
	localparam int PORT_W = 12;

	// channels: index 0 is channel 1
	localparam int NUM_CH = 12;
	localparam int FIRST_HIZ_CH = 4;
	// shared pins: port pin p (4..11) carries channel index PIN_CH_BASE - p
	localparam int ANALOG_PIN_LO = 4;
	localparam int PIN_CH_BASE = 15;

	// command selector codes
	localparam logic [SEL_W-1:0] SEL_SPECIAL = 4'h0;
	localparam logic [SEL_W-1:0] SEL_CH_FIRST = 4'h1;
	localparam logic [SEL_W-1:0] SEL_CH_LAST = 4'hc;
	localparam logic [SEL_W-1:0] SEL_PORT_WR = 4'hd;
	localparam logic [SEL_W-1:0] SEL_PORT_RD = 4'he;
	localparam logic [SEL_W-1:0] SEL_DIR_WR = 4'hf;

	// operation codes in the payload nibble
	localparam logic [OP_W-1:0] OP_ALL_LOAD = 4'hc;
	localparam logic [OP_W-1:0] OP_ALL_HIZ = 4'hd;
	localparam logic [OP_W-1:0] OP_RESET = 4'he;
	localparam logic [OP_W-1:0] OP_CH_LOAD = 4'h0;
	localparam logic [OP_W-1:0] OP_CH_HIZ = 4'h1;

	// reset values
	localparam logic [PORT_W-1:0] DIR_RST = 12'h000;
	localparam logic [PORT_W-1:0] PORT_RST = 12'h000;
	localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
	localparam logic [NUM_CH-1:0] ANALOG_RST = 12'h00f;
	localparam logic [CMD_W-1:0] SHIFT_RST = 16'h0000;
	localparam logic [CODE_W-1:0] SHIFT_HI_CLR = 8'h00;

	// synchroniser bundle: chip select, frame toggle, port pins
	localparam int SYNC_W = PORT_W + 2;
	localparam int SYNC_CS_BIT = PORT_W + 1;
	localparam int SYNC_TGL_BIT = PORT_W;
	localparam logic [SYNC_W-1:0] SYNC_RST = 14'h2000;

	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_ALL_LOAD,
		CMD_ALL_HIZ,
		CMD_RESET,
		CMD_CH_LOAD,
		CMD_CH_HIZ,
		CMD_PORT_WR,
		CMD_PORT_RD,
		CMD_DIR_WR
	} sdec_cmd_e;

endpackage

`default_nettype wire

// ===== sdec_sync.sv
/*
 * sdec_sync: two flip-flop level synchroniser for a bundle of bits.
 * Assumes every bit is a slow level or a toggle; multi-bit words that must
 * stay coherent are not to be passed through here.
 */
`timescale 1ns/1ps
`default_nettype none

module sdec_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== sdec_checker_assertions.sv
/*
 * sdec_checker: port assertions and covers for sdec_core.
 * Assumes a single sys_clk domain; bound to every sdec_core instance.
 */
`timescale 1ns/1ps
`default_nettype none

module sdec_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// serial link
	input wire logic chip_select_n,
	input wire logic serial_out_oe,
	// port and channels
	input wire logic [sdec_pkg::PORT_W-1:0] parallel_port_pins_out,
	input wire logic [sdec_pkg::PORT_W-1:0] parallel_port_pins_oe,
	input wire logic [sdec_pkg::NUM_CH-1:0][sdec_pkg::CODE_W-1:0] analog_channel_codes,
	input wire logic [sdec_pkg::NUM_CH-1:0] analog_channel_outputs_en
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	logic [3:0] quiet;
	logic shared_bad;

	// edges since chip select was last low; state may move only shortly after a rise
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet <= 4'hf;
		end else if (!chip_select_n) begin
			quiet <= 4'h0;
		end else if (quiet != 4'hf) begin
			quiet <= quiet + 4'h1;
		end
	end

	// a shared pin driven as output must not also drive its channel
	always_comb begin
		shared_bad = 1'b0;
		for (int p = 4; p < 12; p++) begin
			shared_bad = shared_bad | (parallel_port_pins_oe[p] & analog_channel_outputs_en[15-p]);
		end
	end

	chk_so_float: assert property (chip_select_n |-> !serial_out_oe)
		else $error("serial output driven while deselected");
	chk_so_drive: assert property (!chip_select_n |-> serial_out_oe)
		else $error("serial output not driven in frame");
	chk_codes_quiet: assert property ((quiet > 4'h8) |-> $stable(analog_channel_codes))
		else $error("codes moved outside command execution");
	chk_port_quiet: assert property ((quiet > 4'h8) |->
		$stable(parallel_port_pins_out) && $stable(parallel_port_pins_oe))
		else $error("port state moved outside command execution");
	chk_enable_quiet: assert property ((quiet > 4'h8) |-> $stable(analog_channel_outputs_en))
		else $error("channel enables moved outside command execution");
	chk_fixed_on: assert property (analog_channel_outputs_en[3:0] == 4'hf)
		else $error("channel 1 to 4 left analog use");
	chk_shared_mask: assert property (!shared_bad)
		else $error("shared pin drives both port and channel");
	chk_reset_state: assert property ($rose(arst_n) |-> analog_channel_codes == '0 &&
		analog_channel_outputs_en == 12'h00f && parallel_port_pins_oe == 12'h000)
		else $error("wrong state after reset");

	cover property ($rose(chip_select_n));
	cover property (parallel_port_pins_oe != 12'h000);
	cover property (analog_channel_outputs_en == 12'hfff);
endmodule

bind sdec_core sdec_checker chk_u (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.chip_select_n(chip_select_n),
	.serial_out_oe(serial_out_oe),
	.parallel_port_pins_out(parallel_port_pins_out),
	.parallel_port_pins_oe(parallel_port_pins_oe),
	.analog_channel_codes(analog_channel_codes),
	.analog_channel_outputs_en(analog_channel_outputs_en)
);

`default_nettype wire

// ===== sdec_host.sv
/*
 * sdec_host: behavioural host that frames 16-bit words on the serial link.
 * Assumes the caller spaces frames through the task only; 32 ns shift clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sdec_host (
	// link toward the device
	output logic shift_clk,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic so_q;
	wire so_line;

	// released line shows the inverse of its last level, never a stale copy
	assign so_line = serial_out_oe ? serial_out : ~so_q;
	always @(posedge shift_clk) so_q <= so_line;

	initial begin
		shift_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end

	// lsb first; shift clock runs only inside the frame
	task automatic frame(input logic [15:0] w, output logic [15:0] r);
		#7 chip_select_n = 1'b0;
		for (int k = 0; k < 16; k++) begin
			serial_in = w[k];
			#16 shift_clk = 1'b1;
			r[k] = so_line;
			#16 shift_clk = 1'b0;
		end
		#16 chip_select_n = 1'b1;
		serial_in = ~serial_in;
		#240; // deselect time so the word executes first
	endtask
endmodule

`default_nettype wire

// ===== tb_serial_dac_expander_command.sv
/*
 * tb_serial_dac_expander_command: command sequences through the host model.
 * Assumes sdec_core, sdec_host and the bound checker are compiled before.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_serial_dac_expander_command;
	logic sys_clk;
	logic arst_n;
	logic [11:0] pin_drv;
	logic [15:0] rd;
	wire shift_clk, cs_n, sdi, so, so_oe;
	wire [11:0] pins_out, pins_oe, pin_wire, en;
	wire [11:0][7:0] codes;
	int error_cnt, cmp_count, cycles;

	// pin level from both drivers
	assign pin_wire = (pins_oe & pins_out) | (~pins_oe & pin_drv);

	sdec_core dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .shift_clk(shift_clk),
		.chip_select_n(cs_n), .serial_in(sdi), .serial_out(so), .serial_out_oe(so_oe),
		.parallel_port_pins_in(pin_wire), .parallel_port_pins_out(pins_out),
		.parallel_port_pins_oe(pins_oe), .analog_channel_codes(codes),
		.analog_channel_outputs_en(en));
	sdec_host host_u (.shift_clk(shift_clk), .chip_select_n(cs_n), .serial_in(sdi),
		.serial_out(so), .serial_out_oe(so_oe));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// hang guard, far above the roughly 700 cycles the tests take
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 8000) begin
			error_cnt++;
			$display("ERROR %0t timeout", $time);
			results();
		end
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic send(input logic [15:0] w);
		host_u.frame(w, rd);
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic check_rst(input logic [11:0] port_exp);
		for (int c = 0; c < 12; c++) check({8'h00, codes[c]}, 16'h0000, "code");
		check({4'h0, en}, 16'h000f, "enables");
		check({4'h0, pins_oe}, 16'h0000, "direction");
		check({4'h0, pins_out}, {4'h0, port_exp}, "port out");
	endtask

	initial begin
		arst_n = 1'b0;
		pin_drv = 12'h000;
		error_cnt = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check_rst(12'h000);
		$display("test reset done");
		// every channel; each frame shifts out the word before it
		for (int c = 1; c <= 12; c++) begin
			send({8'h10 | 8'(c), 4'h0, 4'(c)});
			if (c > 1) check(rd, {8'h10 | 8'(c - 1), 4'h0, 4'(c - 1)}, "echo");
			check({8'h00, codes[c-1]}, {8'h00, 8'h10 | 8'(c)}, "channel code");
		end
		check({4'h0, en}, 16'h0fff, "all on");
		$display("test channel load done");
		// float ch5, refused on ch2, unknown op ignored, reload restores
		send(16'h0015);
		check({4'h0, en}, 16'h0fef, "ch5 float");
		send(16'h0012);
		check({4'h0, en}, 16'h0fef, "ch2 kept");
		send(16'h7723);
		check({8'h00, codes[2]}, 16'h0013, "op ignored");
		send(16'h4405);
		check({4'h0, en}, 16'h0fff, "ch5 back");
		send(16'h00d0);
		check({4'h0, en}, 16'h000f, "all float");
		send(16'h11f0);
		send(16'h2200);
		check({8'h00, codes[0]}, 16'h0011, "special no-op");
		send(16'ha5c0);
		for (int c = 0; c < 12; c++) check({8'h00, codes[c]}, 16'h00a5, "all load");
		$display("test specials done");
		// directions mask shared channel; port write
		send(16'h803f);
		check({4'h0, pins_oe}, 16'h0803, "direction");
		check({4'h0, en}, 16'h0fef, "masked");
		send(16'habcd);
		check({4'h0, pins_out}, 16'h0abc, "port write");
		send(16'h003f);
		check({4'h0, en}, 16'h0fff, "unmasked");
		$display("test port write done");
		// port read: output pins and analog pins read zero
		send(16'h00d0);
		@(posedge sys_clk) pin_drv <= 12'h5a6;
		repeat (4) @(posedge sys_clk);
		send(16'h000e);
		@(posedge sys_clk) pin_drv <= 12'h000;
		send(16'h00f0);
		check(rd, 16'h5a4e, "read");
		send(16'h4c0c);
		@(posedge sys_clk) pin_drv <= 12'hfff;
		repeat (4) @(posedge sys_clk);
		send(16'h000e);
		send(16'h00f0);
		check(rd, 16'hfece, "read analog");
		$display("test port read done");
		// reset command keeps port register and low shift bits
		send(16'h77e0);
		check_rst(12'habc);
		send(16'h00f0);
		check(rd, 16'h00e0, "shift after reset");
		@(posedge sys_clk) arst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check_rst(12'h000);
		$display("test reset command done");
		results();
	end
endmodule

`default_nettype wire
